// *** design/apc_defs.svh ***
/*
 * Constants for the audio processor control block: field positions,
 * reset values and timing counts.
 * Assumes a 250 MHz system clock and an upstream I2C decoder that
 * hands over complete bytes as one-cycle strobes.
 */
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH
`define APC_CLK_MHZ 250
`define APC_CANCEL_NS 300000
`define APC_CANCEL_CYC ((`APC_CANCEL_NS * `APC_CLK_MHZ) / 1000)
`define APC_SUB_HOLD_BIT 6
`define APC_STAT_BUSY_BIT 3
`define APC_SRC_MAX 4'h8
`define APC_SPK_SRC_MIX3 3'h6
`define APC_SPK_FREE_L 4
`define APC_SPK_FREE_R 5
`define APC_LEVEL_MAX 7'h5e
`define APC_BASS_150 4'hf
`define APC_RAMP_T0 20'h007d0
`define APC_RAMP_T1 20'h01f40
`define APC_RAMP_T2 20'h07d00
`define APC_RAMP_T3 20'h1f400
`endif

// *** design/apc_pkg.sv ***
/*
 * Types for the audio processor control block.
 * Assumes apc_defs.svh is included by the users.
 */
package apc_pkg;
   typedef enum logic [1:0] {SM_IDLE, SM_DOWN, SM_MUTED, SM_UP} apc_smstate_t;
   typedef enum logic [3:0] {
      SRC_FULLDIFF, SRC_QUASI, SRC_CD, SRC_MINIDISC, SRC_NAV, SRC_AM, SRC_MPX,
      SRC_AC0, SRC_MONODIFF
   } apc_src_t;
endpackage

// *** design/apc_control.sv ***
/*
 * Control logic of the audio processor: offset cancel sequencing, direct
 * and soft mute, status flag, mute monitor and the tone and speaker settings.
 * Assumes an I2C decoder on clk delivering byte strobes; analog stages
 * take the registered settings as they are.
 */
`timescale 1ns/1ps
`include "apc_defs.svh"
module apc_control #(
   parameter int CANCEL_CYC = `APC_CANCEL_CYC
) (
   input wire logic clk, // 250 MHz clock
   input wire logic reset_n, // Async reset, active low
   input wire logic byteStrobe, // One-cycle data byte valid
   input wire logic [3:0] byteIndex, // Data byte number
   input wire logic [7:0] byteData, // Data byte value
   input wire logic [7:0] subAddress, // Subaddress of transfer
   input wire logic [3:0] mainSource, // Main input select
   input wire logic [3:0] subSource, // Sub channel select
   input wire logic fullDiffQuasi, // Quasi-diff mode request
   input wire logic minidiscMonoDiff, // Mono-diff mode request
   input wire logic directMuteMain, // I2C direct mute main
   input wire logic directMuteSub, // I2C direct mute sub
   input wire logic [3:0] softMuteReq, // I2C soft mute per group
   input wire logic [1:0] muteTimeSel, // Soft mute time select
   input wire logic soft_mute_pin_n, // Soft mute pin, low mutes
   input wire logic alt_freq_search_pin_n, // Search pin, low mutes
   input wire logic [3:0] bassSet, // Attenuation code
   input wire logic [7:0] bassCfg, // Centre, Q, DC code byte
   input wire logic [3:0] midSet, // Mid attenuation
   input wire logic [1:0] midFreq, // Mid centre select
   input wire logic midQ, // Mid Q: 0 is 1, 1 is 2
   input wire logic [3:0] trebleSet, // Treble attenuation
   input wire logic [1:0] trebleFreq, // Treble centre select
   input wire logic [5:0][6:0] speakerLevel, // Level codes, 0 is +15dB
   input wire logic [5:0][2:0] speakerSource, // Speaker source codes
   output logic offsetCancelRun, // Cancel cycle active
   output logic toneMute, // Mute ahead of tone stage
   output logic mainMute, // Direct main mute
   output logic subMute, // Direct sub mute
   output logic [3:0] subSel, // Buffered sub source
   output logic [3:0] mainSel, // Main source
   output logic quasiMode, // Full-diff in quasi mode
   output logic monoDiffMode, // Minidisc in mono-diff
   output logic [3:0] softMuteActive, // Per group mute engaged
   output logic [7:0] rampGain, // Square-law gain, ff full
   output logic [7:0] statusByte, // Readable output register
   output logic muteMonitor, // Monitor on mute pin
   output logic [3:0] bassAtten, // Bass attenuation
   output logic [1:0] bassFreq, // Bass centre
   output logic bass150, // 150Hz centre override
   output logic [1:0] bassQ, // Bass quality
   output logic bassDc, // Bass DC mode
   output logic [3:0] midAtten, // Mid attenuation
   output logic [1:0] midCentre, // Mid centre
   output logic midQ2, // Mid Q of 2
   output logic [3:0] trebleAtten, // Treble attenuation
   output logic [1:0] trebleCentre, // Treble centre
   output logic [5:0][6:0] spkLevel, // Clamped speaker levels
   output logic [5:0][2:0] spkSource // Checked speaker sources
);
   logic rstA, rst;
   logic [2:0] pinSync, afsSync;
   logic pinMute, afsMute;
   logic [18:0] cancelCnt, cancelAge;
   logic [19:0] rampCnt, rampLen;
   apc_pkg::apc_smstate_t smState;
   logic [3:0] reqLatch;
   logic [7:0] s;

   // Reset release through two flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstA <= 1'b0;
         rst <= 1'b0;
      end else begin
         rstA <= 1'b1;
         rst <= rstA;
      end
   end

   // Pin sync, change accepted when stages two and three agree
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         pinSync <= 3'h7;
         afsSync <= 3'h7;
         pinMute <= 1'b0;
         afsMute <= 1'b0;
      end else begin
         pinSync <= {pinSync[1:0], soft_mute_pin_n};
         afsSync <= {afsSync[1:0], alt_freq_search_pin_n};
         if (pinSync[2] == pinSync[1]) pinMute <= ~pinSync[2];
         if (afsSync[2] == afsSync[1]) afsMute <= ~afsSync[2];
      end
   end

   // Offset cancel cycle on byte 0
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         cancelCnt <= 19'h0;
         offsetCancelRun <= 1'b0;
      end else if (byteStrobe && byteIndex == 4'h0 && !subAddress[`APC_SUB_HOLD_BIT]) begin
         cancelCnt <= 19'(CANCEL_CYC - 1);
         offsetCancelRun <= 1'b1;
      end else if (cancelCnt != 19'h0) begin
         cancelCnt <= cancelCnt - 19'h1;
      end else begin
         offsetCancelRun <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst) begin
      if (!rst) toneMute <= 1'b0;
      else toneMute <= (byteStrobe && byteIndex == 4'h0 && !subAddress[`APC_SUB_HOLD_BIT])
                       || (offsetCancelRun && cancelCnt != 19'h0);
   end

   // Source, mode and direct mute settings
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         mainMute <= 1'b1;
         subMute <= 1'b1;
         subSel <= 4'h0;
         mainSel <= 4'h0;
         quasiMode <= 1'b0;
         monoDiffMode <= 1'b0;
      end else begin
         mainMute <= directMuteMain;
         subMute <= directMuteSub;
         // AC zero is a valid code
         if (subSource <= `APC_SRC_MAX) subSel <= subSource;
         if (mainSource <= `APC_SRC_MAX) mainSel <= mainSource;
         quasiMode <= fullDiffQuasi;
         monoDiffMode <= minidiscMonoDiff;
      end
   end

   // Ramp length from time select
   always_comb begin
      case (muteTimeSel)
         2'h0: rampLen = `APC_RAMP_T0;
         2'h1: rampLen = `APC_RAMP_T1;
         2'h2: rampLen = `APC_RAMP_T2;
         default: rampLen = `APC_RAMP_T3;
      endcase
   end

   // Soft mute sequencer
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         smState <= apc_pkg::SM_IDLE;
         rampCnt <= 20'h0;
         reqLatch <= 4'h0;
      end else begin
         case (smState)
            apc_pkg::SM_IDLE: begin
               if (pinMute || afsMute || softMuteReq != 4'h0) begin
                  reqLatch <= (pinMute || afsMute) ? 4'hf : softMuteReq;
                  rampCnt <= rampLen;
                  smState <= apc_pkg::SM_DOWN;
               end
            end
            apc_pkg::SM_DOWN: begin
               if (rampCnt != 20'h0) rampCnt <= rampCnt - 20'h1;
               else smState <= apc_pkg::SM_MUTED;
            end
            apc_pkg::SM_MUTED: begin
               if (!(pinMute || afsMute) && softMuteReq == 4'h0) begin
                  rampCnt <= rampLen;
                  smState <= apc_pkg::SM_UP;
               end else if (!(pinMute || afsMute)) begin
                  reqLatch <= reqLatch | softMuteReq;
               end
            end
            apc_pkg::SM_UP: begin
               if (rampCnt != 20'h0) rampCnt <= rampCnt - 20'h1;
               else smState <= apc_pkg::SM_IDLE;
            end
            default: smState <= apc_pkg::SM_IDLE;
         endcase
      end
   end

   always_comb begin
      // Wide product, the longest ramp times 255 overflows 20 bits
      s = (rampLen == 20'h0) ? 8'h0 : 8'((28'(rampCnt) * 28'hff) / 28'(rampLen));
   end
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) rampGain <= 8'hff;
      else begin
         case (smState)
            apc_pkg::SM_DOWN: rampGain <= 8'((16'(s) * 16'(s)) >> 8);
            apc_pkg::SM_UP: rampGain <= 8'hff - 8'((16'(s) * 16'(s)) >> 8);
            apc_pkg::SM_MUTED: rampGain <= 8'h0;
            default: rampGain <= 8'hff;
         endcase
      end
   end

   // Status flag, monitor and engaged groups
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         statusByte <= 8'h0;
         muteMonitor <= 1'b0;
         softMuteActive <= 4'h0;
      end else begin
         // busy from start to demute end
         statusByte <= 8'(smState != apc_pkg::SM_IDLE) << `APC_STAT_BUSY_BIT;
         muteMonitor <= smState != apc_pkg::SM_IDLE;
         softMuteActive <= (smState == apc_pkg::SM_IDLE) ? 4'h0 : reqLatch;
      end
   end

   // Tone settings
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         bassAtten <= 4'h0;
         bassFreq <= 2'h0;
         bass150 <= 1'b0;
         bassQ <= 2'h0;
         bassDc <= 1'b0;
         midAtten <= 4'h0;
         midCentre <= 2'h0;
         midQ2 <= 1'b0;
         trebleAtten <= 4'h0;
         trebleCentre <= 2'h0;
      end else begin
         bassAtten <= bassSet;
         bassFreq <= bassCfg[1:0];
         bassQ <= bassCfg[3:2];
         // DC mode flag to analog stage
         bassDc <= bassCfg[4];
         bass150 <= bassCfg[5:2] == `APC_BASS_150;
         midAtten <= midSet;
         midCentre <= midFreq;
         midQ2 <= midQ;
         trebleAtten <= trebleSet;
         trebleCentre <= trebleFreq;
      end
   end

   // Per speaker level and source
   for (genvar i = 0; i < 6; i++) begin : g_spk
      always_ff @(posedge clk or negedge rst) begin
         if (!rst) begin
            spkLevel[i] <= `APC_LEVEL_MAX;
            spkSource[i] <= 3'h0;
         end else begin
            spkLevel[i] <= (speakerLevel[i] > `APC_LEVEL_MAX) ? `APC_LEVEL_MAX
                                                                 : speakerLevel[i];
            // DC taps are speakers 4 and 5
            if (speakerSource[i] != `APC_SPK_SRC_MIX3 || i == `APC_SPK_FREE_L
                || i == `APC_SPK_FREE_R)
               spkSource[i] <= speakerSource[i];
         end
      end
   end

   // Cycles of the current cancel run, restarted by every new start
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) cancelAge <= 19'h0;
      else if (byteStrobe && byteIndex == 4'h0 && !subAddress[`APC_SUB_HOLD_BIT])
         cancelAge <= 19'h0;
      else if (offsetCancelRun) cancelAge <= cancelAge + 19'h1;
   end
   // Cancel bounded by its time
   chk_cancel_len: assert property (@(posedge clk) disable iff (!rst)
      cancelAge <= 19'(CANCEL_CYC))
      else $error("cancel too long");
   chk_cancel_mute: assert property (@(posedge clk) disable iff (!rst)
      offsetCancelRun && cancelCnt > 19'h1 |=> toneMute)
      else $error("tone not muted");
   chk_cancel_hold: assert property (@(posedge clk) disable iff (!rst)
      !offsetCancelRun && byteStrobe && subAddress[`APC_SUB_HOLD_BIT] |=> !offsetCancelRun)
      else $error("hold ignored");
   chk_direct_mute: assert property (@(posedge clk) disable iff (!rst)
      directMuteMain |=> mainMute)
      else $error("direct mute missing");
   sequence sDown;
      smState == apc_pkg::SM_DOWN;
   endsequence
   chk_ramp_done: assert property (@(posedge clk) disable iff (!rst)
      sDown ##1 (smState != apc_pkg::SM_DOWN) |-> smState == apc_pkg::SM_MUTED)
      else $error("ramp interrupted");
   chk_busy_flag: assert property (@(posedge clk) disable iff (!rst)
      smState != apc_pkg::SM_IDLE |=> statusByte[`APC_STAT_BUSY_BIT])
      else $error("busy flag low");
   chk_monitor_eq: assert property (@(posedge clk) disable iff (!rst)
      muteMonitor == statusByte[`APC_STAT_BUSY_BIT])
      else $error("monitor differs");
   chk_pin_start: assert property (@(posedge clk) disable iff (!rst)
      smState == apc_pkg::SM_IDLE && pinMute |=> smState == apc_pkg::SM_DOWN)
      else $error("pin mute ignored");
   chk_level_max: assert property (@(posedge clk) disable iff (!rst)
      spkLevel[0] <= `APC_LEVEL_MAX)
      else $error("level out of range");
endmodule

// *** dv/apc_host_model.sv ***
/*
 * Host side model: stands for the host controller and its bus decoder,
 * handing over data bytes as one-cycle strobes.
 * Assumes clk is the block clock and callers wait for reset release.
 */
`timescale 1ns/1ps
module apc_host_model (
   input wire logic clk, // Block clock
   output logic byteStrobe, // Byte valid pulse
   output logic [3:0] byteIndex, // Byte number
   output logic [7:0] byteData, // Byte value
   output logic [7:0] subAddress // Subaddress with hold bit
);
   // Idle bus at time zero
   initial begin
      byteStrobe = 1'b0;
      byteIndex = 4'h0;
      byteData = 8'h00;
      subAddress = 8'h00;
   end

   // One byte write; released data shows its inverse afterwards
   task automatic sendByte(input logic [3:0] idx, input logic [7:0] val, input logic hold);
      @(posedge clk);
      byteStrobe <= 1'b1;
      byteIndex <= idx;
      byteData <= val;
      subAddress <= {1'b0, hold, 6'h15};
      @(posedge clk);
      byteStrobe <= 1'b0;
      byteData <= ~val;
   endtask
endmodule

// *** dv/tb_audio_processor_control.sv ***
/*
 * Self-checking bench for the audio processor control block.
 * Assumes the design package and defines header are compiled first.
 */
`timescale 1ns/1ps
`include "apc_defs.svh"
module tb_audio_processor_control;
   localparam int CCYC = 20;
   logic clk, reset_n, byteStrobe, fullDiffQuasi, minidiscMonoDiff, directMuteMain;
   logic directMuteSub, soft_mute_pin_n, alt_freq_search_pin_n, midQ, offsetCancelRun;
   logic toneMute, mainMute, subMute, quasiMode, monoDiffMode, muteMonitor, bass150, bassDc;
   logic midQ2;
   logic [3:0] byteIndex, mainSource, subSource, softMuteReq, bassSet, midSet, trebleSet;
   logic [3:0] subSel, mainSel, softMuteActive, bassAtten, midAtten, trebleAtten;
   logic [1:0] muteTimeSel, midFreq, trebleFreq, bassFreq, bassQ, midCentre, trebleCentre;
   logic [7:0] byteData, subAddress, bassCfg, rampGain, statusByte;
   logic [5:0][6:0] speakerLevel, spkLevel;
   logic [5:0][2:0] speakerSource, spkSource;
   int errors = 0;
   int cmpCount = 0;
   int seed = 32'h4fdbbc35;
   int rampLen [2] = '{2000, 8000};

   apc_host_model u_host (.clk, .byteStrobe, .byteIndex, .byteData, .subAddress);

   apc_control #(.CANCEL_CYC(CCYC)) u_dut (.clk, .reset_n, .byteStrobe, .byteIndex, .byteData,
      .subAddress, .mainSource, .subSource, .fullDiffQuasi, .minidiscMonoDiff, .directMuteMain,
      .directMuteSub, .softMuteReq, .muteTimeSel, .soft_mute_pin_n, .alt_freq_search_pin_n,
      .bassSet, .bassCfg, .midSet, .midFreq, .midQ, .trebleSet, .trebleFreq, .speakerLevel,
      .speakerSource, .offsetCancelRun, .toneMute, .mainMute, .subMute, .subSel, .mainSel,
      .quasiMode, .monoDiffMode, .softMuteActive, .rampGain, .statusByte, .muteMonitor,
      .bassAtten, .bassFreq, .bass150, .bassQ, .bassDc, .midAtten, .midCentre, .midQ2,
      .trebleAtten, .trebleCentre, .spkLevel, .spkSource);

   // Clock at 250 MHz
   always #2 clk = ~clk;

   // Verdict and end of run
   task automatic stop_test();
      if (errors == 0 && cmpCount > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Compare one value
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait on the busy flag
   task automatic waitBusy(input logic lvl, input int bound, output int n);
      n = 0;
      while (statusByte[3] !== lvl && n < bound) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= bound) begin
         errors++;
         stop_test();
      end
   endtask

   // Withdraw every soft mute request
   task automatic dropReq();
      @(posedge clk);
      softMuteReq <= 4'h0;
      soft_mute_pin_n <= 1'b1;
      alt_freq_search_pin_n <= 1'b1;
   endtask

   // Soft mute cycle; src 0..3 is a group, 4 the mute pin, 5 the search pin
   task automatic softRun(input int sel, input int src, input bit early);
      int n;
      int len;
      logic [3:0] grp;
      len = rampLen[sel];
      grp = (src < 4) ? 4'(1 << src) : 4'hf;
      @(posedge clk);
      muteTimeSel <= sel[1:0];
      if (src < 4) softMuteReq <= grp;
      else if (src == 4) soft_mute_pin_n <= 1'b0;
      else alt_freq_search_pin_n <= 1'b0;
      waitBusy(1'b1, 10, n);
      check("muteMonitor", muteMonitor, 1);
      check("mainMute", mainMute, 0);
      if (early) begin
         repeat (100) @(posedge clk);
         dropReq();
         repeat (900) @(posedge clk);
         #1 check("busy held", statusByte[3], 1);
         check("ramp midway", 32'(rampGain > 8'h0 && rampGain < 8'hff), 1);
         waitBusy(1'b0, 2 * len + 50, n);
         check("busy span", 32'(n + 1000 >= 2 * len), 1);
      end else begin
         repeat (len + 10) @(posedge clk);
         #1 check("rampGain", rampGain, 0);
         check("softMuteActive", softMuteActive, grp);
         dropReq();
         waitBusy(1'b0, len + 50, n);
         check("up time", 32'(n >= len && n <= len + 10), 1);
      end
      check("rampGain", rampGain, 8'hff);
      check("muteMonitor", muteMonitor, 0);
   endtask

   // Random settings compared with their expected registered values
   task automatic settingsRun();
      int expMain = 0;
      int expSub = 0;
      int expSrc [6] = '{default: 0};
      for (int i = 0; i < 24; i++) begin
         @(posedge clk);
         {mainSource, subSource, bassSet, midSet} <= 16'($random(seed));
         {trebleSet, midFreq, trebleFreq, midQ, fullDiffQuasi, minidiscMonoDiff} <=
            11'($random(seed));
         bassCfg <= (i == 0) ? 8'h3c : 8'($random(seed));
         for (int k = 0; k < 6; k++) begin
            speakerLevel[k] <= 7'($random(seed));
            speakerSource[k] <= 3'(i % 7);
         end
         @(posedge clk);
         #1;
         if (mainSource <= `APC_SRC_MAX) expMain = mainSource;
         if (subSource <= `APC_SRC_MAX) expSub = subSource;
         check("mainSel", mainSel, expMain);
         check("subSel", subSel, expSub);
         check("quasiMode", quasiMode, fullDiffQuasi);
         check("monoDiffMode", monoDiffMode, minidiscMonoDiff);
         check("bass", {bassAtten, bassFreq, bassQ, bassDc},
            {bassSet, bassCfg[1:0], bassCfg[3:2], bassCfg[4]});
         check("bassDc", bassDc, bassCfg[4]);
         check("bass150", bass150, bassCfg[5:2] == 4'hf);
         check("mid", {midAtten, midCentre, midQ2}, {midSet, midFreq, midQ});
         check("treble", {trebleAtten, trebleCentre}, {trebleSet, trebleFreq});
         for (int k = 0; k < 6; k++) begin
            check("spkLevel", spkLevel[k], (speakerLevel[k] > `APC_LEVEL_MAX) ?
               `APC_LEVEL_MAX : speakerLevel[k]);
            // Mix source is refused outside the free pair, old code stays
            if (speakerSource[k] != `APC_SPK_SRC_MIX3 || k >= `APC_SPK_FREE_L)
               expSrc[k] = speakerSource[k];
            check("spkSource", spkSource[k], expSrc[k]);
         end
      end
   endtask

   // Main sequence
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      {mainSource, subSource, bassSet, midSet, trebleSet, softMuteReq} = '0;
      {fullDiffQuasi, minidiscMonoDiff, directMuteMain, directMuteSub, midQ} = '0;
      {muteTimeSel, midFreq, trebleFreq, bassCfg} = '0;
      soft_mute_pin_n = 1'b1;
      alt_freq_search_pin_n = 1'b1;
      speakerLevel = '0;
      speakerSource = '0;
      repeat (18) @(posedge clk);
      #1 check("reset mutes", {mainMute, subMute, rampGain}, 10'h3ff);
      check("reset level", spkLevel[5], `APC_LEVEL_MAX);
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge clk);
      // Direct mute in every combination
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         {directMuteSub, directMuteMain} <= 2'(m);
         @(posedge clk);
         #1 check("direct mute", {subMute, mainMute}, m);
      end
      @(posedge clk);
      {directMuteSub, directMuteMain} <= 2'h0;
      // Cancel cycle, retriggered, then a held write and a non-zero byte
      u_host.sendByte(4'h0, 8'h5a, 1'b0);
      #1 check("cancel run", offsetCancelRun, 1);
      check("toneMute", toneMute, 1);
      repeat (8) @(posedge clk);
      u_host.sendByte(4'h0, 8'h5b, 1'b0);
      repeat (CCYC - 1) @(posedge clk);
      #1 check("cancel run", offsetCancelRun, 1);
      @(posedge clk);
      #1 check("cancel end", offsetCancelRun, 0);
      u_host.sendByte(4'h0, 8'h11, 1'b1);
      u_host.sendByte(4'h1, 8'h22, 1'b0);
      for (int j = 0; j < 4; j++) begin
         @(posedge clk);
         #1 check("no cancel", {offsetCancelRun, toneMute}, 0);
      end
      settingsRun();
      for (int g = 0; g < 6; g++) begin
         softRun(g == 4, g, g == 3 || g == 5);
      end
      stop_test();
   end
endmodule
